// ---- hw/adc_result_and_trigger_ctrl.sv ----
// Result registers, auto-trigger select and pin input disable for a converter.
// Assumes a same-clock converter core, same-clock event flags, async pins.
// Functional notes
// - Right adjust: result 9:8 in high byte 1:0, 7:0 in low byte.
// - Left adjust: result 9:2 in high byte, 1:0 in low byte 7:6.
// - Differential pair selected: result shown in two's complement.
// - Low byte read blocks updates of both bytes until high byte read.
// - Trigger source selection ignored while auto trigger disabled.
// - Auto trigger starts a conversion on selected flag's rising edge.
// - Switching selection from clear flag to set flag makes a trigger edge.
// - Switching to free running never makes a trigger event.
// - Codes 0..7: free run, comparator, ext int0, t0 cmp, t0 ovf, t1 cmp b, t1 ovf, t1 capt.
// - Each disable bit switches off that analog pin's digital input buffer.
// - Disabled pin reads zero in the port input value.
// - Done flag set when conversion ends, even if a low byte lock keeps the result registers.
// - Writing one clears the done flag; vector taken also clears it.
`timescale 1ns/100ps
`default_nettype none
module adc_result_and_trigger_ctrl
    import conv_ctrl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [conv_ctrl_pkg::ADDR_W-1:0] addr_in,
    input wire logic [conv_ctrl_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [conv_ctrl_pkg::DATA_W-1:0] rdata_out,
    input wire logic conv_end_in,
    input wire logic [conv_ctrl_pkg::RESULT_W-1:0] conv_result_in,
    input wire logic busy_in,
    input wire logic [conv_ctrl_pkg::NUM_TRIG-1:1] trig_flags_in,
    input wire logic vector_taken_in,
    input wire logic [conv_ctrl_pkg::NUM_PINS-1:0] pin_level_in,
    output logic [conv_ctrl_pkg::NUM_PINS-1:0] pin_input_value_out,
    output logic [conv_ctrl_pkg::NUM_PINS-1:0] pin_buffer_off_out,
    output logic start_conv_out,
    output logic conv_done_flag_out,
    output logic converter_en_out,
    output logic [4:0] input_select_bits_out
);
    import conv_ctrl_pkg::*;

    // ==========================================
    // Register state
    logic [7:0] conv_control_a_q;
    logic [7:0] input_select_reg_q;
    logic [2:0] trigger_source_sel_q;
    logic [7:0] pin_input_disable_bits_q;
    logic conv_done_flag_q;
    logic [9:0] conv_result_bits_q;
    logic result_locked_q;
    logic start_pending_q;
    logic trig_level_q;
    logic [7:0] pin_meta_q;
    logic [7:0] pin_sync_q;
    logic [7:0] rdata_q;
    logic start_conv_q;
    logic wr_ctrl_a, wr_trig, wr_sel, wr_dis;
    logic rd_low, rd_high;
    logic trig_level_d;
    logic trig_pulse;
    logic accept_result;

    assign wr_ctrl_a = wr_in && (addr_in == OFS_CONTROL_A);
    assign wr_trig = wr_in && (addr_in == OFS_TRIGGER_CTRL);
    assign wr_sel = wr_in && (addr_in == OFS_INPUT_SELECT);
    assign wr_dis = wr_in && (addr_in == OFS_PIN_DISABLE);
    assign rd_low = rd_in && (addr_in == OFS_RESULT_LOW);
    assign rd_high = rd_in && (addr_in == OFS_RESULT_HIGH);

    // ==========================================
    // Control registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            conv_control_a_q <= RST_BYTE;
        end else if (wr_ctrl_a) begin
            conv_control_a_q <= wdata_in & CTRL_A_WMASK;
        end
    end

    // Reserved bits are dropped, so they always read zero
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            trigger_source_sel_q <= RST_TRIG_SEL;
        end else if (wr_trig) begin
            trigger_source_sel_q <= wdata_in[2:0];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            input_select_reg_q <= RST_BYTE;
        end else if (wr_sel) begin
            input_select_reg_q <= wdata_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_input_disable_bits_q <= RST_BYTE;
        end else if (wr_dis) begin
            pin_input_disable_bits_q <= wdata_in;
        end
    end

    // ==========================================
    // Trigger selection
    // Free running follows the done flag but never counts as an edge on entry
    always_comb begin
        unique case (trig_src_type'(trigger_source_sel_q))
            TRIG_FREE_RUN: trig_level_d = conv_done_flag_q;
            TRIG_ANALOG_CMP: trig_level_d = trig_flags_in[1];
            TRIG_EXT_INT0: trig_level_d = trig_flags_in[2];
            TRIG_T0_CMP: trig_level_d = trig_flags_in[3];
            TRIG_T0_OVF: trig_level_d = trig_flags_in[4];
            TRIG_T1_CMP_B: trig_level_d = trig_flags_in[5];
            TRIG_T1_OVF: trig_level_d = trig_flags_in[6];
            TRIG_T1_CAPT: trig_level_d = trig_flags_in[7];
        endcase
    end

    // Edge of the muxed level, so a switch to a set source other than free running also makes an edge
    assign trig_pulse = conv_control_a_q[POS_AUTO_TRIGGER_EN]
        && conv_control_a_q[POS_CONVERTER_EN]
        && trig_level_d && !trig_level_q
        && !(wr_trig && wdata_in[2:0] == TRIG_FREE_RUN);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            trig_level_q <= 1'b0;
        end else if (wr_trig && wdata_in[2:0] == TRIG_FREE_RUN) begin
            trig_level_q <= conv_done_flag_q;
        end else begin
            trig_level_q <= trig_level_d;
        end
    end

    // Start request from software bit or trigger; a one-cycle pulse, pending only mirrors busy
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            start_pending_q <= 1'b0;
            start_conv_q <= 1'b0;
        end else begin
            start_conv_q <= trig_pulse
                || (wr_ctrl_a && wdata_in[POS_START] && wdata_in[POS_CONVERTER_EN]);
            start_pending_q <= busy_in;
        end
    end

    // ==========================================
    // Result capture and lock
    // Lock only protects software's byte pair; the finished conversion is lost
    assign accept_result = conv_end_in && !result_locked_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            result_locked_q <= 1'b0;
        end else if (rd_high) begin
            result_locked_q <= 1'b0;
        end else if (rd_low) begin
            result_locked_q <= 1'b1;
        end
    end

    // Core delivers differential results already in two's complement
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            conv_result_bits_q <= RST_RESULT;
        end else if (accept_result) begin
            conv_result_bits_q <= conv_result_in;
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            conv_done_flag_q <= 1'b0;
        end else if (conv_end_in) begin
            conv_done_flag_q <= 1'b1;
        end else if (vector_taken_in || (wr_ctrl_a && wdata_in[POS_DONE_FLAG])) begin
            conv_done_flag_q <= 1'b0;
        end
    end

    // ==========================================
    // Pin input path
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_meta_q <= RST_BYTE;
            pin_sync_q <= RST_BYTE;
        end else begin
            pin_meta_q <= pin_level_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_input_value_out <= RST_BYTE;
            pin_buffer_off_out <= RST_BYTE;
        end else begin
            pin_input_value_out <= pin_sync_q & ~pin_input_disable_bits_q;
            pin_buffer_off_out <= pin_input_disable_bits_q;
        end
    end

    // ==========================================
    // Read port
    always_comb begin
        rdata_q = RST_BYTE;
        unique case (addr_in)
            OFS_RESULT_LOW: rdata_q = input_select_reg_q[POS_ADJUST_LEFT]
                ? {conv_result_bits_q[1:0], 6'h00}
                : conv_result_bits_q[7:0];
            OFS_RESULT_HIGH: rdata_q = input_select_reg_q[POS_ADJUST_LEFT]
                ? conv_result_bits_q[9:2]
                : {6'h00, conv_result_bits_q[9:8]};
            OFS_CONTROL_A: rdata_q = {conv_control_a_q[7], busy_in || start_pending_q,
                conv_control_a_q[5], conv_done_flag_q, conv_control_a_q[3:0]};
            OFS_TRIGGER_CTRL: rdata_q = {5'h00, trigger_source_sel_q};
            OFS_INPUT_SELECT: rdata_q = input_select_reg_q;
            OFS_PIN_DISABLE: rdata_q = pin_input_disable_bits_q;
            default: rdata_q = RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= RST_BYTE;
        end else if (rd_in) begin
            rdata_out <= rdata_q;
        end else begin
            rdata_out <= RST_BYTE;
        end
    end

    // ==========================================
    // Outputs to the converter core
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            start_conv_out <= 1'b0;
            conv_done_flag_out <= 1'b0;
            converter_en_out <= 1'b0;
            input_select_bits_out <= 5'h00;
        end else begin
            start_conv_out <= start_conv_q;
            conv_done_flag_out <= conv_done_flag_q;
            converter_en_out <= conv_control_a_q[POS_CONVERTER_EN];
            input_select_bits_out <= input_select_reg_q[4:0];
        end
    end
endmodule
`default_nettype wire

// ---- hw/conv_ctrl_pkg.sv ----
// Package for the converter result and trigger control block.
// Assumes a byte-wide register port with byte addresses as printed.
package conv_ctrl_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int RESULT_W = 10;
    localparam int NUM_PINS = 8;
    localparam int NUM_TRIG = 8;
    // ==========================================
    // Register offsets
    localparam logic [7:0] OFS_RESULT_LOW = 8'h78;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h79;
    localparam logic [7:0] OFS_CONTROL_A = 8'h7A;
    localparam logic [7:0] OFS_TRIGGER_CTRL = 8'h7B;
    localparam logic [7:0] OFS_INPUT_SELECT = 8'h7C;
    localparam logic [7:0] OFS_PIN_DISABLE = 8'h7E;
    // ==========================================
    // Field positions
    localparam int POS_CONVERTER_EN = 7;
    localparam int POS_START = 6;
    localparam int POS_AUTO_TRIGGER_EN = 5;
    localparam int POS_DONE_FLAG = 4;
    localparam int POS_ADJUST_LEFT = 5;
    localparam int POS_DIFF_SEL = 3;
    localparam int POS_TRIG_SEL_LSB = 0;
    // ==========================================
    // Reset values and write masks
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_TRIG_SEL = 3'h0;
    localparam logic [9:0] RST_RESULT = 10'h000;
    localparam logic [7:0] TRIG_CTRL_WMASK = 8'h07;
    localparam logic [7:0] CTRL_A_WMASK = 8'hEF;

    typedef enum logic [2:0] {
        TRIG_FREE_RUN = 3'h0,
        TRIG_ANALOG_CMP = 3'h1,
        TRIG_EXT_INT0 = 3'h2,
        TRIG_T0_CMP = 3'h3,
        TRIG_T0_OVF = 3'h4,
        TRIG_T1_CMP_B = 3'h5,
        TRIG_T1_OVF = 3'h6,
        TRIG_T1_CAPT = 3'h7
    } trig_src_type;
endpackage

// ---- sim/adc_result_and_trigger_ctrl_checker.sv ----
// Port-level assertions for the converter result and trigger block.
// Assumes one clock and the async high reset of the block's ports.
`timescale 1ns/100ps
`default_nettype none
module adc_result_and_trigger_ctrl_checker
    import conv_ctrl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic conv_end_in,
    input wire logic vector_taken_in,
    input wire logic [7:0] pin_input_value_out,
    input wire logic [7:0] pin_buffer_off_out,
    input wire logic conv_done_flag_out,
    input wire logic converter_en_out,
    input wire logic [4:0] input_select_bits_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ==========================================
    // Read port
    chk_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not zero outside read reply");
    chk_unmapped_zero: assert property (rd_in && addr_in == 8'h00 |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    chk_buf_readback: assert property (rd_in && addr_in == OFS_PIN_DISABLE |=> rdata_out == pin_buffer_off_out)
        else $error("buffer off differs from disable register");
    chk_done_readback: assert property (rd_in && addr_in == OFS_CONTROL_A |=> rdata_out[4] == conv_done_flag_out)
        else $error("done flag readback differs");
    chk_en_readback: assert property (rd_in && addr_in == OFS_CONTROL_A |=> rdata_out[7] == converter_en_out)
        else $error("enable readback differs");
    chk_sel_readback: assert property (rd_in && addr_in == OFS_INPUT_SELECT |=> rdata_out[4:0] == input_select_bits_out)
        else $error("input select readback differs");
    // ==========================================
    // Done flag, set wins over clear
    chk_done_set: assert property (conv_end_in |-> ##2 conv_done_flag_out)
        else $error("done flag not set after conversion end");
    chk_vector_clear: assert property (vector_taken_in && !conv_end_in |-> ##2 !conv_done_flag_out)
        else $error("vector did not clear done flag");
    chk_w1c_clear: assert property (wr_in && addr_in == OFS_CONTROL_A && wdata_in[4] && !conv_end_in
        |-> ##2 !conv_done_flag_out)
        else $error("write one did not clear done flag");
    // Pin masking once the disable setting has settled
    chk_pin_masked: assert property ($stable(pin_buffer_off_out)[*3] |-> (pin_input_value_out & pin_buffer_off_out) == 8'h00)
        else $error("disabled pin reads nonzero");
endmodule
`default_nettype wire

// ---- sim/adc_result_and_trigger_ctrl_test.sv ----
// Self-checking bench for the converter result and trigger block.
// Assumes the package offsets; busy from the core is held low.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module adc_result_and_trigger_ctrl_test;
    import conv_ctrl_pkg::*;
    logic clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, conv_end_in = 0, busy_in = 0, vector_taken_in = 0;
    logic [7:0] addr_in = 0, wdata_in = 0, pin_level_in = 0, rdata_out, pin_input_value_out, pin_buffer_off_out;
    logic [7:0] got, dis;
    logic [7:0] rst_addr [4] = '{8'h78, 8'h79, 8'h7E, 8'h00};
    logic [9:0] conv_result_in = 0, res, old;
    logic [7:1] trig_flags_in = 0;
    logic start_conv_out, conv_done_flag_out, converter_en_out, seen;
    logic [4:0] input_select_bits_out;
    int seed = 91, err_total = 0, cmp_count = 0;
    adc_result_and_trigger_ctrl i_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .conv_end_in(conv_end_in),
        .conv_result_in(conv_result_in), .busy_in(busy_in), .trig_flags_in(trig_flags_in),
        .vector_taken_in(vector_taken_in), .pin_level_in(pin_level_in), .pin_input_value_out(pin_input_value_out),
        .pin_buffer_off_out(pin_buffer_off_out), .start_conv_out(start_conv_out),
        .conv_done_flag_out(conv_done_flag_out), .converter_en_out(converter_en_out),
        .input_select_bits_out(input_select_bits_out));
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    // ==========================================
    // Bus and stimulus tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in) {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
        @(posedge clk_in) wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in) {addr_in, rd_in} <= {a, 1'b1};
        @(posedge clk_in) rd_in <= 1'b0;
        #1 got = rdata_out;
    endtask
    task automatic conv(input logic [9:0] r);
        @(posedge clk_in) {conv_result_in, conv_end_in} <= {r, 1'b1};
        @(posedge clk_in) conv_end_in <= 1'b0;
    endtask
    // Five edges cover the two-cycle start latency with margin
    task automatic watch_start();
        seen = 0;
        repeat (5) @(posedge clk_in) #1 seen |= (start_conv_out === 1'b1);
    endtask
    function automatic logic [7:0] hi_of(logic [9:0] r, logic l);
        return l ? r[9:2] : {6'h00, r[9:8]};
    endfunction
    function automatic logic [7:0] lo_of(logic [9:0] r, logic l);
        return l ? {r[1:0], 6'h00} : r[7:0];
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        foreach (rst_addr[i]) begin
            rd(rst_addr[i]);
            `CHK("reset value", 8'h00, got)
        end
        dis = $random(seed);
        wr(OFS_PIN_DISABLE, dis);
        @(posedge clk_in) pin_level_in <= $random(seed);
        repeat (4) @(posedge clk_in);
        #1 `CHK("pin value", pin_level_in & ~dis, pin_input_value_out)
        `CHK("buffer off", dis, pin_buffer_off_out)
        rd(OFS_PIN_DISABLE);
        `CHK("disable readback", dis, got)
        for (int i = 0; i < 8; i++) begin
            res = (i < 2) ? {10{i[0]}} : $random(seed);
            wr(OFS_INPUT_SELECT, {2'b00, i[1], 5'h00});
            conv(res);
            rd(OFS_RESULT_LOW);
            `CHK("result low", lo_of(res, i[1]), got)
            rd(OFS_RESULT_HIGH);
            `CHK("result high", hi_of(res, i[1]), got)
        end
        `CHK("done set", 1'b1, conv_done_flag_out)
        rd(OFS_INPUT_SELECT);
        `CHK("select readback", 8'h20, got)
        old = res;
        rd(OFS_RESULT_LOW);
        conv(~old);
        rd(OFS_RESULT_HIGH);
        `CHK("locked high", hi_of(old, 1'b1), got)
        wr(OFS_CONTROL_A, 8'h10);
        repeat (2) @(posedge clk_in);
        #1 `CHK("done clear", 1'b0, conv_done_flag_out)
        conv(10'h155);
        @(posedge clk_in) vector_taken_in <= 1'b1;
        @(posedge clk_in) vector_taken_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1 `CHK("vector clear", 1'b0, conv_done_flag_out)
        wr(OFS_CONTROL_A, 8'hB0);
        for (int c = 1; c < 8; c++) begin
            wr(OFS_TRIGGER_CTRL, 8'(c));
            @(posedge clk_in) trig_flags_in[c] <= 1'b1;
            watch_start();
            `CHK("source start", 1'b1, seen)
            @(posedge clk_in) trig_flags_in <= '0;
        end
        wr(OFS_TRIGGER_CTRL, 8'h01);
        @(posedge clk_in) trig_flags_in[3] <= 1'b1;
        wr(OFS_TRIGGER_CTRL, 8'h03);
        watch_start();
        `CHK("switch start", 1'b1, seen)
        @(posedge clk_in) trig_flags_in <= '0;
        conv(10'h2AA);
        wr(OFS_TRIGGER_CTRL, 8'h00);
        watch_start();
        `CHK("free run switch", 1'b0, seen)
        wr(OFS_CONTROL_A, 8'h90);
        wr(OFS_TRIGGER_CTRL, 8'h01);
        @(posedge clk_in) trig_flags_in[1] <= 1'b1;
        watch_start();
        `CHK("auto off", 1'b0, seen)
        rd(OFS_CONTROL_A);
        `CHK("control readback", 8'h80, got)
        rd(OFS_TRIGGER_CTRL);
        `CHK("trigger readback", 8'h01, got)
        give_verdict();
    end
endmodule
bind adc_result_and_trigger_ctrl adc_result_and_trigger_ctrl_checker i_chk (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .conv_end_in(conv_end_in), .vector_taken_in(vector_taken_in), .pin_input_value_out(pin_input_value_out),
    .pin_buffer_off_out(pin_buffer_off_out), .conv_done_flag_out(conv_done_flag_out),
    .converter_en_out(converter_en_out), .input_select_bits_out(input_select_bits_out));
`default_nettype wire
